// ### hw/stx_master.sv
// Master-transmit serial channel with APB register access.
// Overview of operation
// (R1) Word length bit: 0 shifts 7 bits, 1 shifts 8 bits.
// (R2) Bit order bit: 0 MSB first, 1 LSB first.
// (R3) Phase bit 1 puts first bit half a clock before clocking.
// (R4) Polarity bit 1 inverts the serial clock output.
// (R5) Event source: 0 transfer end, 1 buffer empty.
// (R6) Clock select picks prescaler output zero or one.
// (R7) Data register upper bits divide clock; half rate only first channel.
// (R8) Software writes transmit word into low byte of data register.
// (R9) Software presets idle clock level to match polarity before start.
// (R10) Output enable bit must be set to drive serial data.
// (R11) Start trigger write of 1 enables channel; 0 has no effect.
// (R12) Stop trigger write of 1 stops channel, clearing enable status.
// (R13) Clearing output enable after stop halts serial output.
// (R14) Stopped and disabled channel lets software set pin levels.
// (R15) Removing unit clock resets all channel state; the code keeps shiftReg and bitsLeft.
// (R16) Software waits for word in progress before stopping.
// (R17) After clock removal software reinitialises instead of resuming.
// (R18) Write while buffer full replaces the buffered word.
// (R19) Event source may change until the last bit starts.
// (R20) Stop trigger clears itself once enable status reads 0.
// (R21) Unit clock off: writes ignored, reads return defaults; the code reads back zero.
// (R22) Buffer-empty event fires when buffered word enters shifter.
// (R23) Transfer flag holds from shift start until last bit out.
`timescale 1ns/1ps
module stx_master (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset_n,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial pins and event.
  output stx_pkg::stx_pins_s serialPins,
  output logic channelTransferIrq
);
  import stx_pkg::*;

  logic unitEn, next_unitEn;
  logic [15:0] modeCfg, next_modeCfg;
  logic [15:0] commCfg, next_commCfg;
  logic [15:0] dataDiv, next_dataDiv;
  logic [15:0] outLvl, next_outLvl;
  logic outEn, next_outEn;
  logic enStat, next_enStat;
  logic stopTrig, next_stopTrig;
  logic [7:0] prescale, next_prescale;
  logic bufFull, next_bufFull;
  logic [7:0] shiftReg, next_shiftReg;
  logic [3:0] bitsLeft, next_bitsLeft;
  logic [15:0] preCnt, next_preCnt;
  logic [7:0] divCnt, next_divCnt;
  stx_state_e state, next_state;
  logic [31:0] next_prdata;
  logic next_pready, next_irq;
  stx_pins_s next_pins;
  logic access, wr, rd;

  assign access = psel && penable && !pready;
  assign wr = access && pwrite;
  assign rd = access && !pwrite;

  // Next bit to put out given order and length.
  function automatic logic pickBit(input logic [7:0] w, input logic lsb,
                                   input logic len8);
    pickBit = lsb ? w[0] : (len8 ? w[7] : w[6]);
  endfunction : pickBit

  // Shift one bit away in the selected direction.
  function automatic logic [7:0] shiftOn(input logic [7:0] w,
                                         input logic lsb);
    shiftOn = lsb ? {1'b0, w[7:1]} : {w[6:0], 1'b0};
  endfunction : shiftOn

  logic opTick, divDone, lsbFirst, len8, phase1, invClk;
  logic [3:0] psSel;
  logic [6:0] divVal;
  assign lsbFirst = commCfg[COMM_ORDER_BIT]; // [R2]
  assign len8 = commCfg[COMM_LEN_BIT]; // [R1]
  assign phase1 = commCfg[COMM_PHASE_BIT];
  assign invClk = commCfg[COMM_POL_BIT];
  // Prescaler nibble per select; output ticks once per 2^n cycles.
  assign psSel = modeCfg[MODE_CLKSEL_BIT] ? prescale[7:4] : prescale[3:0]; // [R6]
  assign divVal = dataDiv[15:9]; // [R7]

  always_comb begin
    next_preCnt = preCnt + 16'h0001;
    opTick = (psSel == 4'h0) || ((preCnt & ((16'h0001 << psSel) - 16'h0001))
      == 16'h0000);
    // Start one count in, so that the first half of a word lasts as long
    // as every later half instead of ending on the very first cycle.
    if (state == STX_IDLE) begin
      next_preCnt = 16'h0001; // [R6] [R7]
    end
  end

  // Half-period counter: divides by (divider+1); non-first channels
  // are held at a divider of at least one so they never reach fclk/2.
  logic [6:0] effDiv;
  assign effDiv = (!FIRST_CHANNEL && divVal < MIN_DIV_OTHER) ? MIN_DIV_OTHER
    : divVal; // [R7]
  assign divDone = opTick && (divCnt == {1'b0, effDiv});

  always_comb begin
    next_unitEn = unitEn;
    next_modeCfg = modeCfg;
    next_commCfg = commCfg;
    next_dataDiv = dataDiv;
    next_outLvl = outLvl;
    next_outEn = outEn;
    next_enStat = enStat;
    next_stopTrig = stopTrig;
    next_prescale = prescale;
    next_bufFull = bufFull;
    next_shiftReg = shiftReg;
    next_bitsLeft = bitsLeft;
    next_divCnt = divCnt;
    next_state = state;
    next_irq = 1'b0;
    // Shifter.
    if (opTick) begin
      next_divCnt = divDone ? 8'h00 : divCnt + 8'h01;
    end
    case (state)
      STX_IDLE: begin
        next_divCnt = 8'h00;
        if (enStat && bufFull) begin
          next_shiftReg = dataDiv[7:0];
          next_bufFull = 1'b0; // [R22]
          next_bitsLeft = len8 ? 4'h8 : 4'h7; // [R1]
          next_state = phase1 ? STX_LEAD : STX_LOW; // [R3]
          next_irq = modeCfg[MODE_IRQSRC_BIT]; // [R5] [R22]
        end
      end
      STX_LEAD: begin
        if (divDone) begin
          next_state = STX_LOW; // [R3]
        end
      end
      STX_LOW: begin
        if (divDone) begin
          next_state = STX_HIGH;
        end
      end
      default: begin
        if (divDone) begin
          next_shiftReg = shiftOn(shiftReg, lsbFirst); // [R2]
          next_bitsLeft = bitsLeft - 4'h1;
          if (bitsLeft == 4'h1) begin
            // Event source sampled at word end, so late changes count.
            next_irq = !modeCfg[MODE_IRQSRC_BIT]; // [R5] [R19]
            if (enStat && bufFull) begin
              next_shiftReg = dataDiv[7:0];
              next_bufFull = 1'b0; // [R22]
              next_bitsLeft = len8 ? 4'h8 : 4'h7;
              next_state = STX_LOW;
              next_irq = 1'b1; // [R5]
            end else begin
              next_state = STX_IDLE; // [R23]
            end
          end else begin
            next_state = STX_LOW;
          end
        end
      end
    endcase
    if (!enStat) begin
      next_state = STX_IDLE; // [R12]
    end
    next_stopTrig = stopTrig && enStat; // [R20]
    // Register writes other than unit enable, ignored while the unit clock is off.
    if (wr && paddr == OFF_UNITEN) begin
      next_unitEn = pwdata[0];
    end else if (wr && unitEn) begin // [R21]
      if (paddr == OFF_MODE) begin
        next_modeCfg = pwdata[15:0];
      end else if (paddr == OFF_COMM) begin
        next_commCfg = pwdata[15:0];
      end else if (paddr == OFF_DATA) begin
        next_dataDiv = pwdata[15:0]; // [R8]
        next_bufFull = 1'b1; // [R18]
      end else if (paddr == OFF_OUTLVL) begin
        next_outLvl = pwdata[15:0]; // [R9] [R14]
      end else if (paddr == OFF_OUTEN) begin
        next_outEn = pwdata[0]; // [R10] [R13]
      end else if (paddr == OFF_START) begin
        next_enStat = enStat | pwdata[0]; // [R11]
      end else if (paddr == OFF_STOP && pwdata[0]) begin
        next_enStat = 1'b0; // [R12]
        next_stopTrig = 1'b1;
      end else if (paddr == OFF_PRESCALE) begin
        next_prescale = pwdata[7:0];
      end
    end
    // Unit clock off holds registers and shifter state at defaults; shiftReg and bitsLeft keep their values.
    if (!unitEn) begin // [R15]
      next_modeCfg = RST_MODE;
      next_commCfg = RST_COMM;
      next_dataDiv = RST_DATA;
      next_outLvl = RST_OUTLVL;
      next_outEn = 1'b0;
      next_enStat = 1'b0;
      next_stopTrig = 1'b0;
      next_prescale = RST_PRESCALE;
      next_bufFull = 1'b0;
      next_state = STX_IDLE;
    end
  end

  // Read path: data stands only in the cycle of pready, zero otherwise.
  always_comb begin
    next_pready = access;
    next_prdata = prdata;
    if (pready) begin
      next_prdata = 32'h0000_0000;
    end
    if (rd) begin
      next_prdata = 32'h0000_0000;
      if (paddr == OFF_UNITEN) begin
        next_prdata = {31'h0000_0000, unitEn};
      end else if (!unitEn) begin
        next_prdata = 32'h0000_0000; // [R21]
      end else if (paddr == OFF_MODE) begin
        next_prdata = {16'h0000, modeCfg};
      end else if (paddr == OFF_COMM) begin
        next_prdata = {16'h0000, commCfg};
      end else if (paddr == OFF_DATA) begin
        next_prdata = {16'h0000, dataDiv};
      end else if (paddr == OFF_STATUS) begin
        next_prdata[STAT_ACTIVE_BIT] = (state != STX_IDLE); // [R23]
        next_prdata[STAT_FULL_BIT] = bufFull;
      end else if (paddr == OFF_OUTLVL) begin
        next_prdata = {16'h0000, outLvl};
      end else if (paddr == OFF_OUTEN) begin
        next_prdata = {31'h0000_0000, outEn};
      end else if (paddr == OFF_STOP) begin
        next_prdata = {31'h0000_0000, stopTrig};
      end else if (paddr == OFF_ENSTAT) begin
        next_prdata = {31'h0000_0000, enStat};
      end else if (paddr == OFF_PRESCALE) begin
        next_prdata = {24'h00_0000, prescale};
      end
    end
  end

  // Pin drive: the clock idles at the software level, toggles low then
  // high per bit, and polarity inverts it.
  always_comb begin
    next_pins.dataOe = outEn; // [R10] [R13]
    next_pins.clk = outLvl[OUTLVL_CLK_BIT]; // [R14]
    next_pins.data = outLvl[OUTLVL_DATA_BIT]; // [R14]
    if (next_state != STX_IDLE) begin
      next_pins.clk = (next_state == STX_LOW) ^ invClk ? 1'b0 : 1'b1; // [R4]
      next_pins.data = pickBit(next_shiftReg, lsbFirst, len8);
    end
  end

  // Software-visible configuration and control state.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      unitEn <= 1'b0;
      modeCfg <= RST_MODE;
      commCfg <= RST_COMM;
      dataDiv <= RST_DATA;
      outLvl <= RST_OUTLVL;
      outEn <= 1'b0;
      enStat <= 1'b0;
      stopTrig <= 1'b0;
      prescale <= RST_PRESCALE;
      bufFull <= 1'b0;
    end else begin
      unitEn <= next_unitEn;
      modeCfg <= next_modeCfg;
      commCfg <= next_commCfg;
      dataDiv <= next_dataDiv;
      outLvl <= next_outLvl;
      outEn <= next_outEn;
      enStat <= next_enStat;
      stopTrig <= next_stopTrig;
      prescale <= next_prescale;
      bufFull <= next_bufFull;
    end
  end

  // Shifter, its counters and the channel event.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      shiftReg <= 8'h00;
      bitsLeft <= 4'h0;
      preCnt <= 16'h0000;
      divCnt <= 8'h00;
      state <= STX_IDLE;
      channelTransferIrq <= 1'b0;
    end else begin
      shiftReg <= next_shiftReg;
      bitsLeft <= next_bitsLeft;
      preCnt <= next_preCnt;
      divCnt <= next_divCnt;
      state <= next_state;
      channelTransferIrq <= next_irq;
    end
  end

  // Bus answer.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
    end else begin
      prdata <= next_prdata;
      pready <= next_pready;
    end
  end

  // Pins come from flip-flops so the far side never sees decode glitches.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      serialPins <= '{clk: 1'b1, data: 1'b1, dataOe: 1'b0};
    end else begin
      serialPins <= next_pins;
    end
  end

  assign pslverr = 1'b0;
endmodule : stx_master

// ### shared/stx_pkg.sv
// Package with register map, field layout and types of the serial transmitter.
package stx_pkg;
  // Register byte offsets.
  localparam logic [7:0] OFF_MODE = 8'h00;
  localparam logic [7:0] OFF_COMM = 8'h04;
  localparam logic [7:0] OFF_DATA = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  localparam logic [7:0] OFF_OUTLVL = 8'h10;
  localparam logic [7:0] OFF_OUTEN = 8'h14;
  localparam logic [7:0] OFF_START = 8'h18;
  localparam logic [7:0] OFF_STOP = 8'h1c;
  localparam logic [7:0] OFF_ENSTAT = 8'h20;
  localparam logic [7:0] OFF_PRESCALE = 8'h24;
  localparam logic [7:0] OFF_UNITEN = 8'h28;
  // Mode register fields.
  localparam int MODE_CLKSEL_BIT = 15;
  localparam int MODE_IRQSRC_BIT = 0;
  // Communication register fields.
  localparam int COMM_PHASE_BIT = 13;
  localparam int COMM_POL_BIT = 12;
  localparam int COMM_ORDER_BIT = 7;
  localparam int COMM_LEN_BIT = 0;
  // Output level register fields.
  localparam int OUTLVL_CLK_BIT = 8;
  localparam int OUTLVL_DATA_BIT = 0;
  // Status register fields.
  localparam int STAT_ACTIVE_BIT = 6;
  localparam int STAT_FULL_BIT = 0;
  // Reset values.
  localparam logic [15:0] RST_MODE = 16'h0020;
  localparam logic [15:0] RST_COMM = 16'h0087;
  localparam logic [15:0] RST_DATA = 16'h0000;
  localparam logic [15:0] RST_OUTLVL = 16'h0101;
  localparam logic [7:0] RST_PRESCALE = 8'h00;
  // Divider of first channel may reach half the system clock.
  localparam logic FIRST_CHANNEL = 1'b1;
  localparam logic [6:0] MIN_DIV_OTHER = 7'h01;
  // Shifter states.
  typedef enum logic [1:0] {
    STX_IDLE = 2'b00,
    STX_LEAD = 2'b01,
    STX_LOW = 2'b10,
    STX_HIGH = 2'b11
  } stx_state_e;
  // Serial pins bundled.
  typedef struct packed {
    logic clk;
    logic data;
    logic dataOe;
  } stx_pins_s;
endpackage : stx_pkg

// ### testbench/stx_master_checker.sv
// Checker of bus and serial pin timing of the transmitter.
`timescale 1ns/1ps
module stx_master_checker (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset_n,
  // APB.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Serial side.
  input wire stx_pkg::stx_pins_s serialPins,
  input wire logic channelTransferIrq
);
  import stx_pkg::*;
  logic take;
  logic unitOn;
  logic pol;
  logic [3:0] offHist;
  logic [2:0] oeAge;
  assign take = psel && penable && pwrite && !pready;
  // Shadows snooped from the bus, since the checker cannot see registers.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      unitOn <= 1'b0;
      pol <= 1'b0;
      offHist <= 4'h0;
      oeAge <= 3'h7;
    end else begin
      if (take && paddr == OFF_UNITEN) unitOn <= pwdata[0];
      if (!unitOn) begin
        pol <= 1'b0;
      end else if (take && paddr == OFF_COMM) begin
        pol <= pwdata[COMM_POL_BIT];
      end
      offHist <= {offHist[2:0], !unitOn};
      if (take && (paddr == OFF_OUTEN || paddr == OFF_UNITEN)) begin
        oeAge <= 3'h0;
      end else if (oeAge != 3'h7) begin
        oeAge <= oeAge + 3'h1;
      end
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  property p_ready_wait;
    psel && penable && !pready |=> pready;
  endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("late pready");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("long pready");
  property p_ready_cause;
    pready |-> $past(psel) && $past(penable);
  endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("stray pready");
  property p_rdata_idle;
    !pready |-> prdata == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("stray prdata");
  property p_no_err;
    !pslverr;
  endproperty
  a_no_err: assert property (p_no_err) else $error("pslverr set");
  property p_irq_pulse;
    channelTransferIrq |=> !channelTransferIrq;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("long irq");
  property p_oe_cause;
    $changed(serialPins.dataOe) |-> oeAge < 3'h6;
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("oe moved");
  property p_sample_stable;
    (pol ? $fell(serialPins.clk) : $rose(serialPins.clk))
      |-> $stable(serialPins.data);
  endproperty
  a_sample_stable: assert property (p_sample_stable) else $error("data moved");
  property p_unit_off;
    &offHist |-> serialPins == 3'b110 && !channelTransferIrq;
  endproperty
  a_unit_off: assert property (p_unit_off) else $error("unit off active");
endmodule : stx_master_checker
bind stx_master stx_master_checker u_chk (
  .core_clk(core_clk),
  .reset_n(reset_n),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .serialPins(serialPins),
  .channelTransferIrq(channelTransferIrq)
);

// ### testbench/stx_slave_model.sv
// Receiving slave that shifts in data on each active clock edge.
`timescale 1ns/1ps
module stx_slave_model (
  // Serial lines and polarity.
  input wire logic sclk,
  input wire logic sdata,
  input wire logic pol,
  // Received bits.
  output logic [7:0] rx,
  output int bits
);
  initial begin
    rx = 8'h00;
    bits = 0;
  end
  // Active edge brings the clock back to its idle level.
  always @(sclk) begin
    if (sclk === !pol) begin
      rx = {rx[6:0], sdata};
      bits = bits + 1;
    end
  end
endmodule : stx_slave_model

// ### testbench/tb_stx_master.sv
// Self-checking bench of the serial transmitter.
`timescale 1ns/1ps
module tb_stx_master;
  import stx_pkg::*;
  typedef struct {logic [15:0] mode, comm, data;} stx_row_s;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, r;
  logic pready, pslverr, channelTransferIrq, pol = 1'b0;
  stx_pins_s serialPins;
  logic [7:0] rx;
  int bits, mismatches = 0, compares = 0, lowCyc = 0, irqCnt = 0;
  int irqBits = 0, n, m, b0, l0, i0;
  stx_row_s rows [6] = '{'{16'h0000, 16'h0001, 16'h00a5},
    '{16'h0001, 16'h0000, 16'h0036}, '{16'h0000, 16'h0081, 16'h02c3},
    '{16'h0001, 16'h1080, 16'h0059}, '{16'h8000, 16'h2001, 16'h004e},
    '{16'h0001, 16'h3001, 16'h00f0}};
  always #20 core_clk = ~core_clk;
  stx_master u_dut (.core_clk(core_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serialPins(serialPins), .channelTransferIrq(channelTransferIrq));
  stx_slave_model u_slave (.sclk(serialPins.clk), .sdata(serialPins.data),
    .pol(pol), .rx(rx), .bits(bits));
  always @(posedge core_clk) begin
    lowCyc <= lowCyc + (serialPins.clk === pol);
    if (channelTransferIrq === 1'b1) begin
      irqCnt <= irqCnt + 1;
      irqBits <= bits;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    r = prdata;
    if (k >= 20) chk(32'h0, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(r, e);
  endtask : rdc
  // Polls until neither a word is shifting nor one waits in the buffer.
  task automatic idle();
    int k;
    k = 0;
    do begin
      apb(1'b0, OFF_STATUS, 32'h0);
      k++;
    end while ((r[6] | r[0]) !== 1'b0 && k < 60);
    chk(r, 32'h0);
  endtask : idle
  function automatic logic [7:0] expRx(input logic [7:0] d, input logic lsb,
                                       input int k);
    logic [7:0] e;
    e = 8'h00;
    for (int j = 0; j < k; j++) e[lsb ? k - 1 - j : j] = d[j];
    return e;
  endfunction : expRx
  task automatic results();
    if (mismatches == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  initial begin
    repeat (10000) @(posedge core_clk);
    mismatches++;
    results();
  end
  initial begin
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    chk({29'h0, serialPins}, 32'h6);
    apb(1'b1, OFF_COMM, 32'h1);
    apb(1'b1, OFF_UNITEN, 32'h1);
    rdc(OFF_COMM, {16'h0, RST_COMM});
    rdc(OFF_MODE, {16'h0, RST_MODE});
    rdc(OFF_OUTLVL, {16'h0, RST_OUTLVL});
    rdc(8'h30, 32'h0);
    apb(1'b1, OFF_OUTEN, 32'h1);
    apb(1'b1, OFF_PRESCALE, 32'h10);
    apb(1'b1, OFF_START, 32'h1);
    apb(1'b1, OFF_START, 32'h0);
    rdc(OFF_ENSTAT, 32'h1);
    chk({31'h0, serialPins.dataOe}, 32'h1);
    foreach (rows[i]) begin
      pol = rows[i].comm[12];
      n = rows[i].comm[0] ? 8 : 7;
      m = (rows[i].mode[15] ? 2 : 1) * (rows[i].data[15:9] + 1);
      apb(1'b1, OFF_MODE, {16'h0, rows[i].mode});
      apb(1'b1, OFF_COMM, {16'h0, rows[i].comm});
      apb(1'b1, OFF_OUTLVL, pol ? 32'h1 : 32'h101);
      repeat (2) @(posedge core_clk);
      b0 = bits;
      l0 = lowCyc;
      i0 = irqCnt;
      apb(1'b1, OFF_DATA, {16'h0, rows[i].data});
      idle();
      chk(rx & (n == 8 ? 8'hff : 8'h7f), expRx(rows[i].data[7:0],
          rows[i].comm[7], n));
      chk(bits - b0, n);
      chk(lowCyc - l0, n * m);
      chk(irqCnt - i0, 1);
      chk(irqBits - b0, rows[i].mode[0] ? 0 : n);
    end
    pol = 1'b0;
    apb(1'b1, OFF_MODE, 32'h0);
    apb(1'b1, OFF_COMM, 32'h1);
    apb(1'b1, OFF_OUTLVL, 32'h101);
    repeat (2) @(posedge core_clk);
    b0 = bits;
    i0 = irqCnt;
    apb(1'b1, OFF_DATA, 32'h11);
    apb(1'b1, OFF_DATA, 32'h22);
    apb(1'b1, OFF_DATA, 32'h33);
    idle();
    chk(rx, 32'h33);
    chk(bits - b0, 16);
    chk(irqCnt - i0, 2);
    // All-ones word, so the abort cannot move data under a clock edge.
    apb(1'b1, OFF_DATA, 32'hff);
    apb(1'b1, OFF_STOP, 32'h1);
    rdc(OFF_ENSTAT, 32'h0);
    rdc(OFF_STOP, 32'h0);
    apb(1'b1, OFF_OUTEN, 32'h0);
    apb(1'b1, OFF_OUTLVL, 32'h0);
    repeat (2) @(posedge core_clk);
    chk({29'h0, serialPins}, 32'h0);
    apb(1'b1, OFF_OUTLVL, 32'h100);
    apb(1'b1, OFF_OUTLVL, 32'h101);
    apb(1'b1, OFF_OUTEN, 32'h1);
    apb(1'b1, OFF_START, 32'h1);
    apb(1'b1, OFF_UNITEN, 32'h0);
    repeat (4) @(posedge core_clk);
    chk({29'h0, serialPins}, 32'h6);
    apb(1'b1, OFF_UNITEN, 32'h1);
    rdc(OFF_ENSTAT, 32'h0);
    rdc(OFF_OUTEN, 32'h0);
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk({29'h0, serialPins}, 32'h6);
    reset_n <= 1'b1;
    @(posedge core_clk);
    results();
  end
endmodule : tb_stx_master
